// ===== qop_top.sv
`timescale 1ns/1ps
module qop_top (
    input  wire logic                      CLK,
    input  wire logic                      RSTN,
    input  wire logic                      WR_EN,
    input  wire logic [qop_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [qop_pkg::DATA_W-1:0] WDATA,
    output logic      [qop_pkg::DATA_W-1:0] RDATA,
    input  wire logic [3:0]                COMP_RAW,
    input  wire logic [3:0]                COMP_INVERT,
    input  wire qop_pkg::qop_dbt_t [3:0]   DEBOUNCE_TIME,
    input  wire logic [3:0]                COMP_DEBOUNCED,
    output logic      [3:0]                COMP_TO_DEBOUNCE,
    output logic      [3:0]                GPO_OUT,
    output logic      [3:0]                GPO_OE,
    output logic      [3:0]                GPO_PD_EN
);
    import qop_pkg::*;

    // ****************************************
    // Helpers.
    // ****************************************
    function automatic logic is_cfg_addr(input logic [ADDR_W-1:0] a);
        return (a >= CFG_BASE_ADDR) && (a <= CFG_LAST_ADDR);
    endfunction

    // One bit per channel, set where the pin follows the shared level register.
    function automatic logic [NUM_CH-1:0] shared_mask(input qop_cfg_t [NUM_CH-1:0] c);
        logic [NUM_CH-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            m[i] = (c[i].source_select_field == SEL_SHARED);
        end
        return m;
    endfunction

    // An undriven pin keeps its level low, so enabling it later never shows a stale level.
    function automatic qop_pin_t pin_drive(input qop_cfg_t c, input logic shared_bit, input logic comp);
        qop_pin_t p;
        p = '{level: 1'b0, oe: 1'b0, pd_en: 1'b0};
        case (c.source_select_field)
            SEL_PULLDOWN: p.pd_en = 1'b1;
            SEL_PRIVATE: p = '{level: c.private_level_bit, oe: 1'b1, pd_en: 1'b0};
            SEL_SHARED: p = '{level: shared_bit, oe: 1'b1, pd_en: 1'b0};
            SEL_COMPARATOR: p = '{level: comp, oe: 1'b1, pd_en: 1'b0};
            default: p = '{level: 1'b0, oe: 1'b0, pd_en: 1'b0};
        endcase
        return p;
    endfunction

    // ****************************************
    // Register file.
    // ****************************************
    logic [3:0]               shared;
    logic [3:0]               next_shared;
    qop_cfg_t [NUM_CH-1:0]    cfg;
    qop_cfg_t [NUM_CH-1:0]    next_cfg;
    logic [DATA_W-1:0]        next_rdata;
    logic [1:0]               idx;

    // Reserved bits are never stored, so they read back as zero whatever was written.
    // Read data is registered: RDATA answers the address that stood at the previous edge.
    always_comb begin
        next_shared = shared;
        next_cfg    = cfg;
        idx         = 2'(ADDR - CFG_BASE_ADDR);
        if (WR_EN && ADDR == SHARED_ADDR) begin
            next_shared = WDATA[LEVEL_LSB +: LEVEL_W];
        end
        if (WR_EN && is_cfg_addr(ADDR)) begin
            next_cfg[idx] = qop_cfg_t'({WDATA[DATA_BIT], WDATA[SEL_LSB +: SEL_W]});
        end
        next_rdata = '0;
        if (ADDR == SHARED_ADDR) begin
            next_rdata = {12'h000, shared};
        end else if (is_cfg_addr(ADDR)) begin
            next_rdata = {12'h000, cfg[idx]};
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            shared <= SHARED_RESET;
            cfg    <= {NUM_CH{qop_cfg_t'(CFG_RESET)}};
            RDATA  <= '0;
        end else begin
            shared <= next_shared;
            cfg    <= next_cfg;
            RDATA  <= next_rdata;
        end
    end

    // ****************************************
    // Comparator path and pin drivers.
    // ****************************************
    logic [3:0] comp_eff;
    logic [3:0] comp_sel;
    logic [3:0] next_out;
    logic [3:0] next_oe;
    logic [3:0] next_pd;
    qop_pin_t   pin;

    // The invert bit acts ahead of both the bypass path and the debouncer feed.
    always_comb begin
        comp_eff = COMP_RAW ^ COMP_INVERT;
        next_out = '0;
        next_oe  = '0;
        next_pd  = '0;
        comp_sel = '0;
        pin      = '{level: 1'b0, oe: 1'b0, pd_en: 1'b0};
        for (int i = 0; i < NUM_CH; i++) begin
            comp_sel[i] = (DEBOUNCE_TIME[i] == DEBOUNCE_BYPASS) ? comp_eff[i] : COMP_DEBOUNCED[i];
            pin         = pin_drive(cfg[i], shared[i], comp_sel[i]);
            next_out[i] = pin.level;
            next_oe[i]  = pin.oe;
            next_pd[i]  = pin.pd_en;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            GPO_OUT          <= '0;
            GPO_OE           <= '0;
            GPO_PD_EN        <= '1;
            COMP_TO_DEBOUNCE <= '0;
        end else begin
            GPO_OUT          <= next_out;
            GPO_OE           <= next_oe;
            GPO_PD_EN        <= next_pd;
            COMP_TO_DEBOUNCE <= comp_eff;
        end
    end

    // ****************************************
    // Checks.
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence s_shared_write;
        WR_EN && ADDR == SHARED_ADDR;
    endsequence

    a_shared_reg_load: assert property (s_shared_write ##1 1'b1 |-> shared == $past(WDATA[3:0]))
        else $error("shared level register did not load");
    a_reserved_read_zero: assert property (RDATA[15:4] == 12'h000)
        else $error("reserved read bits not zero");
    a_cfg_write_map: assert property (WR_EN && ADDR == CFG_BASE_ADDR |=> cfg[0] == $past(WDATA[3:0]))
        else $error("channel A source register not at base address");
    sequence s_cfg_steady;
        cfg == $past(cfg);
    endsequence

    // A shared write with steady source registers must reach every shared-mode pin at once.
    a_group_update: assert property (s_shared_write ##1 s_cfg_steady ##1 s_cfg_steady
        |-> (GPO_OUT & shared_mask(cfg)) == ($past(WDATA[LEVEL_LSB +: LEVEL_W], 2) & shared_mask(cfg)))
        else $error("shared-mode pins did not update together");

    // ****************************************
    // Register bus, debouncer feed and pull-down exclusivity checks.
    // ****************************************
    a_shared_hold: assert property (!(WR_EN && ADDR == SHARED_ADDR)
        |=> shared == $past(shared))
        else $error("shared level register changed without a write");
    a_unmapped_write: assert property (WR_EN && ADDR != SHARED_ADDR && !is_cfg_addr(ADDR)
        |=> shared == $past(shared) && cfg == $past(cfg))
        else $error("write to an unmapped address changed a register");
    a_shared_readback: assert property (ADDR == SHARED_ADDR
        |=> RDATA == {12'h000, $past(shared)})
        else $error("shared level register read back wrong");
    a_unmapped_read: assert property (ADDR != SHARED_ADDR && !is_cfg_addr(ADDR)
        |=> RDATA == 16'h0000)
        else $error("unmapped address did not read zero");
    a_feed_invert: assert property (1'b1
        |=> COMP_TO_DEBOUNCE == ($past(COMP_RAW) ^ $past(COMP_INVERT)))
        else $error("debouncer feed not inverted as set");
    a_pull_exclusive: assert property ((GPO_OE & GPO_PD_EN) == 4'h0)
        else $error("pull-down attached to a driven pin");

    // ****************************************
    // Per-channel pin and register checks.
    // ****************************************
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
        a_pulldown_mode: assert property (
            cfg[g].source_select_field == SEL_PULLDOWN
            |=> GPO_PD_EN[g] && !GPO_OE[g])
            else $error("pull-down mode wrong");
        a_private_drive: assert property (
            cfg[g].source_select_field == SEL_PRIVATE
            |=> GPO_OE[g] && GPO_OUT[g] == $past(cfg[g].private_level_bit))
            else $error("private level not driven");
        a_shared_drive: assert property (
            cfg[g].source_select_field == SEL_SHARED
            |=> GPO_OE[g] && GPO_OUT[g] == $past(shared[g]))
            else $error("shared level not driven");
        a_debounced_drive: assert property (
            cfg[g].source_select_field == SEL_COMPARATOR && DEBOUNCE_TIME[g] != DEBOUNCE_BYPASS
            |=> GPO_OE[g] && GPO_OUT[g] == $past(COMP_DEBOUNCED[g]))
            else $error("debounced comparator not driven");
        a_bypass_invert: assert property (
            cfg[g].source_select_field == SEL_COMPARATOR && DEBOUNCE_TIME[g] == DEBOUNCE_BYPASS
            |=> GPO_OUT[g] == ($past(COMP_RAW[g]) ^ $past(COMP_INVERT[g])))
            else $error("bypassed comparator path wrong");
        a_hiz_mode: assert property (
            cfg[g].source_select_field >= SEL_HIZ
            |=> !GPO_OE[g] && !GPO_PD_EN[g])
            else $error("high impedance mode wrong");
        a_comparator_oe: assert property (
            cfg[g].source_select_field == SEL_COMPARATOR
            |=> GPO_OE[g] && !GPO_PD_EN[g])
            else $error("comparator mode pin not driven");
        a_cfg_write_load: assert property (
            WR_EN && ADDR == 8'(CFG_BASE_ADDR + g)
            |=> cfg[g] == $past(WDATA[3:0]))
            else $error("source register not loaded at its address");
        a_cfg_hold: assert property (
            !(WR_EN && ADDR == 8'(CFG_BASE_ADDR + g))
            |=> cfg[g] == $past(cfg[g]))
            else $error("source register changed without a write");
        a_cfg_readback: assert property (
            ADDR == 8'(CFG_BASE_ADDR + g)
            |=> RDATA == {12'h000, $past(cfg[g])})
            else $error("source register read back wrong");
    end

endmodule

// ===== qop_pkg.sv
// Overview of operation
// - Shared level register bits 0..3 set pins A..D when in shared mode.
// - Select 000 leaves the pin undriven with the weak pull-down enabled.
// - Select 001 drives the pin from the channel's private level bit.
// - Select 010 drives the pin from its shared level bit.
// - Select 011 drives the pin with the debounced comparator result.
// - Select 100 holds the pin in high impedance without pull resistor.
// - Select codes 101, 110 and 111 also give high impedance.
// - Four pin source registers sit at consecutive addresses, channel A lowest.
// - Shared level register resets to zero; bits 15..4 read zero, ignore writes.
// - Zero debounce time bypasses debounce; comparator result feeds select 011 directly.
// - Comparator invert bit set inverts the comparator result before that path.
package qop_pkg;

    // ****************************************
    // Register map and fields.
    // ****************************************
    localparam int              ADDR_W          = 8;
    localparam int              DATA_W          = 16;
    localparam int              NUM_CH          = 4;
    localparam logic [7:0]      SHARED_ADDR     = 8'h0D;
    localparam logic [7:0]      CFG_BASE_ADDR   = 8'h0E;
    localparam logic [7:0]      CFG_LAST_ADDR   = 8'h11;
    localparam logic [3:0]      SHARED_RESET    = 4'h0;
    localparam logic [3:0]      CFG_RESET       = 4'h0;
    localparam int              LEVEL_LSB       = 0;
    localparam int              LEVEL_W         = 4;
    localparam int              DATA_BIT        = 3;
    localparam int              SEL_LSB         = 0;
    localparam int              SEL_W           = 3;

    // ****************************************
    // Source select codes.
    // ****************************************
    localparam logic [2:0]      SEL_PULLDOWN    = 3'h0;
    localparam logic [2:0]      SEL_PRIVATE     = 3'h1;
    localparam logic [2:0]      SEL_SHARED      = 3'h2;
    localparam logic [2:0]      SEL_COMPARATOR  = 3'h3;
    localparam logic [2:0]      SEL_HIZ         = 3'h4;
    localparam logic [4:0]      DEBOUNCE_BYPASS = 5'h00;

    typedef logic [4:0] qop_dbt_t;

    typedef struct packed {
        logic       private_level_bit;
        logic [2:0] source_select_field;
    } qop_cfg_t;

    typedef struct packed {
        logic level;
        logic oe;
        logic pd_en;
    } qop_pin_t;

endpackage

// ===== qop_top_tb.sv
`timescale 1ns/1ps
module qop_top_tb;
    import qop_pkg::*;
    logic                  CLK            = 1'b0;
    logic                  RSTN           = 1'b0;
    logic                  WR_EN          = 1'b0;
    logic [7:0]            ADDR           = 8'h00;
    logic [15:0]           WDATA          = 16'h0000;
    logic [3:0]            COMP_RAW       = 4'h0;
    logic [3:0]            COMP_INVERT    = 4'h0;
    logic [3:0]            COMP_DEBOUNCED = 4'hC;
    qop_dbt_t [3:0]        DBT            = '0;
    logic [15:0]           RDATA;
    logic [3:0]            COMP_TO_DEBOUNCE;
    logic [3:0]            GPO_OUT;
    logic [3:0]            GPO_OE;
    logic [3:0]            GPO_PD_EN;
    int                    err_count      = 0;
    int                    num_checks     = 0;
    int                    cycles         = 0;
    logic [3:0]            e_oe;
    logic [3:0]            e_out;

    qop_top uut (.CLK(CLK), .RSTN(RSTN), .WR_EN(WR_EN), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA),
        .COMP_RAW(COMP_RAW), .COMP_INVERT(COMP_INVERT), .DEBOUNCE_TIME(DBT), .COMP_DEBOUNCED(COMP_DEBOUNCED),
        .COMP_TO_DEBOUNCE(COMP_TO_DEBOUNCE), .GPO_OUT(GPO_OUT), .GPO_OE(GPO_OE), .GPO_PD_EN(GPO_PD_EN));

    always #25 CLK = ~CLK;

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // The run is some 120 cycles; a hang is cut off well beyond that.
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        WR_EN = 1'b1;
        ADDR  = a;
        WDATA = d;
        @(negedge CLK);
        WR_EN = 1'b0;
        @(negedge CLK);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        ADDR = a;
        @(negedge CLK);
        chk(RDATA, exp);
    endtask

    task automatic pins(input logic [3:0] oe, input logic [3:0] out, input logic [3:0] pd);
        chk(16'(GPO_OE), 16'(oe));
        chk(16'(GPO_PD_EN), 16'(pd));
        chk(16'(GPO_OUT & oe), 16'(out));
    endtask

    initial begin
        @(negedge CLK);
        pins(4'h0, 4'h0, 4'hF);
        @(negedge CLK);
        RSTN = 1'b1;
        for (int a = 13; a < 18; a++) rd(8'(a), 16'h0000);
        wr(8'h0D, 16'hFFFF);
        rd(8'h0D, 16'h000F);
        wr(8'h12, 16'hFFFF);
        rd(8'h12, 16'h0000);
        for (int i = 0; i < 4; i++) wr(8'(14 + i), 16'(16'hFFF8 + i));
        for (int i = 0; i < 4; i++) rd(8'(14 + i), 16'(16'h0008 + i));
        $display("test registers done");
        wr(8'h0D, 16'h0005);
        COMP_RAW = 4'h3;
        for (int s = 0; s < 8; s++) begin
            for (int i = 0; i < 4; i++) wr(8'(14 + i), {12'h000, i[0], 3'(s)});
            e_oe  = (s > 0 && s < 4) ? 4'hF : 4'h0;
            e_out = (s == 1) ? 4'hA : (s == 2) ? 4'h5 : (s == 3) ? 4'h3 : 4'h0;
            pins(e_oe, e_out, (s == 0) ? 4'hF : 4'h0);
        end
        $display("test select codes done");
        for (int i = 0; i < 4; i++) wr(8'(14 + i), 16'h0002);
        WR_EN = 1'b1;
        ADDR  = 8'h0D;
        WDATA = 16'h000A;
        @(negedge CLK);
        WR_EN = 1'b0;
        chk(16'(GPO_OUT), 16'h0005);
        @(negedge CLK);
        chk(16'(GPO_OUT), 16'h000A);
        $display("test shared update done");
        for (int i = 0; i < 4; i++) wr(8'(14 + i), 16'h0003);
        COMP_INVERT = 4'h5;
        @(negedge CLK);
        @(negedge CLK);
        chk(16'(COMP_TO_DEBOUNCE), 16'h0006);
        pins(4'hF, 4'h6, 4'h0);
        DBT = {4{5'h01}};
        COMP_DEBOUNCED = 4'h9;
        @(negedge CLK);
        @(negedge CLK);
        pins(4'hF, 4'h9, 4'h0);
        $display("test comparator done");
        RSTN = 1'b0;
        @(negedge CLK);
        pins(4'h0, 4'h0, 4'hF);
        chk(16'(COMP_TO_DEBOUNCE), 16'h0000);
        chk(RDATA, 16'h0000);
        RSTN = 1'b1;
        rd(8'h0D, 16'h0000);
        rd(8'h11, 16'h0000);
        pins(4'h0, 4'h0, 4'hF);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
